// [hdl/capture_compare_unit.sv]
// capture/compare unit: channel timer with three capture/compare channels,
// compare-only timer with one compare channel, and a pattern output unit
// assumes cap_in synchronous-free pins, one clock, avalon-mm master keeps the request until waitrequest low
`include "ccu_cfg.svh"
module capture_compare_unit
  import ccu_pkg::*;
#(
  parameter int NCH = 3,
  parameter int TW  = 16,
  parameter int PW  = 6
)(
  input  wire logic            clock,
  input  wire logic            sys_rst,
  input  wire logic            clk_en,
  input  wire logic [5:0]      avs_address,
  input  wire logic            avs_read,
  input  wire logic            avs_write,
  input  wire logic [31:0]     avs_writedata,
  output logic      [31:0]     avs_readdata,
  output logic                 avs_waitrequest,
  input  wire logic [NCH-1:0]  cap_in,
  output logic      [NCH:0]    cmp_out,
  output logic      [PW-1:0]   pattern_out,
  output logic                 irq
);
  // ****************
  // register file state
  // ****************
  logic [1:0]                run_q;
  logic [TW-1:0]             t12_per_q, t13_per_q, t12_cnt_q, t13_cnt_q;
  ch_cfg_t [NCH-1:0]         cfg_q;
  logic [NCH:0][TW-1:0]      cc_q;
  logic [PW-1:0]             pat_q;
  logic [2*(NCH+1)-1:0]      mod_sel_q;
  logic [`ST_W-1:0]          status_q, mask_q;
  logic [NCH:0]              match;
  logic [NCH-1:0]            cap_evt;
  logic [NCH:0]              cap_hit;
  logic [NCH-1:0]            s1_q, s2_q, s3_q;
  logic                      ack_q;
  bus_req_t                  req;
  logic                      wr_go, rd_go;

  assign req   = '{addr: avs_address, read: avs_read, write: avs_write, wdata: avs_writedata};
  // one wait cycle: read data lands on the edge that sees the request, a write on the edge after
  assign wr_go = clk_en && req.write && ack_q;
  assign rd_go = clk_en && req.read && !ack_q;

  // ****************
  // bus handshake
  // ****************
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      ack_q <= 1'b0;
    else if (clk_en)
      ack_q <= (req.read || req.write) && !ack_q;
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
      avs_waitrequest <= 1'b1;
    else if (clk_en)
      avs_waitrequest <= !((req.read || req.write) && !ack_q);
  end

  // ****************
  // configuration writes
  // ****************
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      run_q     <= '0;
      t12_per_q <= `PER_RST;
      t13_per_q <= `PER_RST;
      cfg_q     <= '0;
      pat_q     <= '0;
      mod_sel_q <= '0;
      mask_q    <= '0;
    end
    else if (wr_go)
    begin
      unique case (req.addr)
        `OFS_CTRL:    run_q     <= req.wdata[1:0];
        `OFS_T12_PER: t12_per_q <= req.wdata[TW-1:0];
        `OFS_T13_PER: t13_per_q <= req.wdata[TW-1:0];
        `OFS_CH_CFG:  cfg_q     <= req.wdata[NCH*`CFG_W-1:0];
        `OFS_PATTERN: pat_q     <= req.wdata[PW-1:0];
        `OFS_MOD_SEL: mod_sel_q <= req.wdata[2*(NCH+1)-1:0];
        `OFS_MASK:    mask_q    <= req.wdata[`ST_W-1:0];
        default:      ;
      endcase
    end
  end

  // ****************
  // timers
  // ****************
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      t12_cnt_q <= `ZERO16;
    else if (clk_en && run_q[`CTRL_RUN12])
      t12_cnt_q <= (t12_cnt_q == t12_per_q) ? `ZERO16 : t12_cnt_q + `ONE16;
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
      t13_cnt_q <= `ZERO16;
    else if (clk_en && run_q[`CTRL_RUN13])
      t13_cnt_q <= (t13_cnt_q == t13_per_q) ? `ZERO16 : t13_cnt_q + `ONE16;
  end

  // ****************
  // capture inputs
  // ****************
  // s1 only feeds s2; edges from s2 against s3
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end
    else if (clk_en)
    begin
      s1_q <= cap_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  always_comb
  begin
    for (int i = 0; i < NCH; i++)
    begin
      unique case (cfg_q[i].edge_sel)
        edge_rise: cap_evt[i] = s2_q[i] && !s3_q[i];
        edge_fall: cap_evt[i] = !s2_q[i] && s3_q[i];
        edge_both: cap_evt[i] = s2_q[i] ^ s3_q[i];
        edge_none: cap_evt[i] = 1'b0;
      endcase
      cap_evt[i] = cap_evt[i] && cfg_q[i].cap_en && clk_en;
    end
  end

  // compare-only channel never sees a capture event
  assign cap_hit = {1'b0, cap_evt};

  // ****************
  // capture/compare values
  // ****************
  // capture wins over a software write of the same channel in the same cycle;
  // channel 3 belongs to the compare-only timer and has no capture path
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      cc_q <= '0;
    else
    begin
      for (int i = 0; i <= NCH; i++)
      begin
        if (cap_hit[i])
          cc_q[i] <= t12_cnt_q;
        else if (wr_go && req.addr == `OFS_CC0 + 6'(4 * i))
          cc_q[i] <= req.wdata[TW-1:0];
      end
    end
  end

  // ****************
  // compare and output actions
  // ****************
  // last channel belongs to the compare-only timer and always runs pwm
  logic      [NCH:0][TW-1:0] cnt_of;
  cmp_mode_t [NCH:0]         mode_of;
  always_comb
  begin
    for (int i = 0; i < NCH; i++)
    begin
      cnt_of[i]  = t12_cnt_q;
      mode_of[i] = cfg_q[i].cmp;
    end
    cnt_of[NCH]  = t13_cnt_q;
    mode_of[NCH] = cmp_pwm;
  end

  always_comb
  begin
    for (int i = 0; i <= NCH; i++)
      match[i] = cnt_of[i] == cc_q[i];
  end

  // compare runs regardless of capture enable, so both work at once
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      cmp_out <= '0;
    else if (clk_en)
    begin
      for (int i = 0; i <= NCH; i++)
      begin
        unique case (mode_of[i])
          cmp_set:    if (match[i]) cmp_out[i] <= 1'b1;
          cmp_clear:  if (match[i]) cmp_out[i] <= 1'b0;
          cmp_toggle: if (match[i]) cmp_out[i] <= !cmp_out[i];
          cmp_pulse:  cmp_out[i] <= match[i];
          cmp_pwm:    cmp_out[i] <= cnt_of[i] < cc_q[i];
          default:    cmp_out[i] <= 1'b0;
        endcase
      end
    end
  end

  // ****************
  // pattern unit
  // ****************
  // mod_sel low half enables channel outputs, high half inverts them; enabled ones are anded
  logic mod_sig;
  always_comb
  begin
    mod_sig = 1'b1;
    for (int i = 0; i <= NCH; i++)
      if (mod_sel_q[i])
        mod_sig = mod_sig && (cmp_out[i] ^ mod_sel_q[NCH + 1 + i]);
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
      pattern_out <= '0;
    else if (clk_en)
      pattern_out <= pat_q & {PW{mod_sig}};
  end

  // ****************
  // interrupts
  // ****************
  // set beats a write-one clear in the same cycle
  logic [`ST_W-1:0] st_set, st_clr;
  always_comb
  begin
    st_set = '0;
    st_set[`ST_CAP_LO +: NCH]   = cap_evt;
    st_set[`ST_CMP_LO +: NCH+1] = match & {(NCH+1){clk_en}};
    st_clr = (wr_go && req.addr == `OFS_STATUS) ? req.wdata[`ST_W-1:0] : '0;
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
      status_q <= '0;
    else
      status_q <= (status_q & ~st_clr) | st_set;
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
      irq <= 1'b0;
    else if (clk_en)
      irq <= |(status_q & mask_q);
  end

  // ****************
  // read data
  // ****************
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      avs_readdata <= `RD_DFLT;
    else if (rd_go)
    begin
      avs_readdata <= `RD_DFLT;
      unique case (req.addr)
        `OFS_CTRL:    avs_readdata[1:0]             <= run_q;
        `OFS_T12_PER: avs_readdata[TW-1:0]          <= t12_per_q;
        `OFS_T13_PER: avs_readdata[TW-1:0]          <= t13_per_q;
        `OFS_T12_CNT: avs_readdata[TW-1:0]          <= t12_cnt_q;
        `OFS_T13_CNT: avs_readdata[TW-1:0]          <= t13_cnt_q;
        `OFS_CH_CFG:  avs_readdata[NCH*`CFG_W-1:0]  <= cfg_q;
        `OFS_CC0:     avs_readdata[TW-1:0]          <= cc_q[0];
        `OFS_CC1:     avs_readdata[TW-1:0]          <= cc_q[1];
        `OFS_CC2:     avs_readdata[TW-1:0]          <= cc_q[2];
        `OFS_CC3:     avs_readdata[TW-1:0]          <= cc_q[3];
        `OFS_PATTERN: avs_readdata[PW-1:0]          <= pat_q;
        `OFS_MOD_SEL: avs_readdata[2*(NCH+1)-1:0]   <= mod_sel_q;
        `OFS_STATUS:  avs_readdata[`ST_W-1:0]       <= status_q;
        `OFS_MASK:    avs_readdata[`ST_W-1:0]       <= mask_q;
        `OFS_OUT:     avs_readdata[NCH:0]           <= cmp_out;
        default:      ;
      endcase
    end
  end

  // ****************
  // checks
  // ****************
  property p_capture_latch;
    @(posedge clock) disable iff (sys_rst)
    cap_evt[0] |=> cc_q[0] == $past(t12_cnt_q);
  endproperty
  a_capture_latch: assert property (p_capture_latch) else $error("capture value wrong");

  property p_capture_irq;
    @(posedge clock) disable iff (sys_rst)
    cap_evt[1] |=> status_q[`ST_CAP_LO + 1];
  endproperty
  a_capture_irq: assert property (p_capture_irq) else $error("capture flag not set");

  property p_rise_only;
    @(posedge clock) disable iff (sys_rst)
    (cfg_q[0].edge_sel == edge_rise && cap_evt[0] && $past(clk_en) && $past(clk_en, 2) && $past(clk_en, 3))
      |-> $past(cap_in[0], 2) && !$past(cap_in[0], 3);
  endproperty
  a_rise_only: assert property (p_rise_only) else $error("rising capture on wrong edge");

  property p_set_mode;
    @(posedge clock) disable iff (sys_rst)
    (clk_en && cfg_q[0].cmp == cmp_set && match[0]) |=> cmp_out[0];
  endproperty
  a_set_mode: assert property (p_set_mode) else $error("set on match missing");

  property p_toggle_mode;
    @(posedge clock) disable iff (sys_rst)
    (clk_en && cfg_q[1].cmp == cmp_toggle && match[1]) |=> cmp_out[1] != $past(cmp_out[1]);
  endproperty
  a_toggle_mode: assert property (p_toggle_mode) else $error("toggle on match missing");

  property p_compare_flag;
    @(posedge clock) disable iff (sys_rst)
    (clk_en && t13_cnt_q == cc_q[NCH]) |=> status_q[`ST_CMP_LO + NCH];
  endproperty
  a_compare_flag: assert property (p_compare_flag) else $error("compare flag missed");

  property p_no_cap_t13;
    @(posedge clock) disable iff (sys_rst)
    !(wr_go && req.addr == `OFS_CC3) |=> $stable(cc_q[NCH]);
  endproperty
  a_no_cap_t13: assert property (p_no_cap_t13) else $error("compare-only channel changed");

  property p_irq_level;
    @(posedge clock) disable iff (sys_rst)
    (clk_en && |(status_q & mask_q)) |=> irq;
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("interrupt not raised");

  property p_pattern_gate;
    @(posedge clock) disable iff (sys_rst)
    (clk_en && !mod_sig) |=> pattern_out == '0;
  endproperty
  a_pattern_gate: assert property (p_pattern_gate) else $error("pattern not gated");
endmodule

// [hdl/ccu_cfg.svh]
// register offsets, field positions, reset values and encodings of the capture/compare unit
// assumes inclusion wherever the macros are read; the guard keeps one copy per unit
`ifndef CCU_CFG_SVH
`define CCU_CFG_SVH
// ****************
// register map (byte addresses)
// ****************
`define OFS_CTRL      6'h00
`define OFS_T12_PER   6'h04
`define OFS_T13_PER   6'h08
`define OFS_T12_CNT   6'h0c
`define OFS_T13_CNT   6'h10
`define OFS_CH_CFG    6'h14
`define OFS_CC0       6'h18
`define OFS_CC1       6'h1c
`define OFS_CC2       6'h20
`define OFS_CC3       6'h24
`define OFS_PATTERN   6'h28
`define OFS_MOD_SEL   6'h2c
`define OFS_STATUS    6'h30
`define OFS_MASK      6'h34
`define OFS_OUT       6'h38
// ****************
// field positions and values
// ****************
`define CTRL_RUN12    0
`define CTRL_RUN13    1
`define CFG_W         6
`define CFG_CAP_EN    0
`define CFG_EDGE_LO   1
`define CFG_CMP_LO    3
`define ST_CAP_LO     0
`define ST_CMP_LO     3
`define ST_W          7
`define PER_RST       16'hffff
`define ZERO16        16'h0000
`define ONE16         16'h0001
`define RD_DFLT       32'h0000_0000
`endif

// [hdl/ccu_pkg.sv]
// types shared by the capture/compare unit
// assumes ccu_cfg.svh is on the include path
package ccu_pkg;
  `include "ccu_cfg.svh"
  typedef enum logic [1:0] {edge_rise, edge_fall, edge_both, edge_none} edge_sel_t;
  // five compare modes; 3'h6..3'h7 act as off
  typedef enum logic [2:0] {cmp_off, cmp_set, cmp_clear, cmp_toggle, cmp_pulse, cmp_pwm,
                            cmp_rsv6, cmp_rsv7} cmp_mode_t;
  typedef struct packed {
    cmp_mode_t cmp;
    edge_sel_t edge_sel;
    logic      cap_en;
  } ch_cfg_t;
  typedef struct packed {
    logic [5:0] addr;
    logic       read;
    logic       write;
    logic [31:0] wdata;
  } bus_req_t;
endpackage

// [sim/pin_model.sv]
// pin-side partner: capture pin levels of the channel timer channels
// assumes the bench asks for one-cycle toggle requests at clock edges
module pin_model (
  input  wire logic       clock,
  input  wire logic       sys_rst,
  input  wire logic [2:0] flip,
  output logic      [2:0] cap_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************
  // pin levels
  // ****************
  // levels move only on request, so every edge seen is one the bench asked for
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      cap_in <= 3'h0;
    else
      cap_in <= cap_in ^ flip;
  end
endmodule

// [sim/tb_top.sv]
// bench for the capture/compare unit: avalon-mm master, pin partner, checks
// assumes one 200 MHz clock and a synchronous active-high reset
`include "ccu_cfg.svh"
module tb_top;
  import ccu_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock;
  logic        sys_rst;
  logic        clk_en;
  logic [5:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [2:0]  cap_in;
  logic [2:0]  flip;
  logic [3:0]  cmp_out;
  logic [5:0]  pattern_out;
  logic        irq;
  int          err_count;
  int          n_checks;
  int          cyc;
  logic [31:0] q;
  logic [15:0] c12;
  logic [15:0] c13;
  logic [15:0] cur;
  logic [15:0] alt;
  logic [5:0]  pat;
  logic [2:0]  mode_t_[5] = '{3'h1, 3'h3, 3'h2, 3'h4, 3'h5};
  logic        hit_t_[5]  = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
  logic        out_t_[5]  = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
  logic [7:0]  sel_t_[4]  = '{8'h00, 8'h01, 8'h08, 8'h88};
  capture_compare_unit i_dut (.clock(clock), .sys_rst(sys_rst), .clk_en(clk_en), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .cap_in(cap_in), .cmp_out(cmp_out), .pattern_out(pattern_out),
    .irq(irq));
  pin_model i_pins (.clock(clock), .sys_rst(sys_rst), .flip(flip), .cap_in(cap_in));
  // ****************
  // clock, timeout, helpers
  // ****************
  initial
  begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  // whole run needs at most about 1100 cycles; over thirty times that marks a hang
  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      err_count++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      $display("[ERR] %s expected %h seen %h", nm, e, g);
      err_count++;
    end
  endtask
  // request held until waitrequest is sampled low, released at that edge, then one idle edge
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d, output logic [31:0] r);
    avs_address   <= a;
    avs_writedata <= d;
    avs_read      <= ~wr;
    avs_write     <= wr;
    @(posedge clock);
    while (avs_waitrequest !== 1'b0)
      @(posedge clock);
    r = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clock);
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask
  task automatic pin(input int ch);
    flip <= 3'h1 << ch;
    @(posedge clock);
    flip <= 3'h0;
    repeat (8) @(posedge clock);
  endtask
  function automatic logic [31:0] cfg(input int ch, input logic [5:0] v);
    return 32'(v) << (ch * 6);
  endfunction
  // ****************
  // main sequence
  // ****************
  initial
  begin
    clk_en        = 1'b1;
    sys_rst       = 1'b1;
    avs_read      = 1'b0;
    avs_write     = 1'b0;
    avs_address   = 6'h00;
    avs_writedata = 32'h0;
    flip          = 3'h0;
    err_count     = 0;
    n_checks      = 0;
    cyc           = 0;
    repeat (20) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    void'($urandom(99));
    bus(1'b0, `OFS_T13_PER, 0, q);
    chk("per13", 32'h0000ffff, q);
    bus(1'b0, 6'h3c, 0, q);
    chk("unmapped", 32'h0, q);
    wr(`OFS_T12_PER, 32'h0100);
    wr(`OFS_CTRL, 32'h3);
    repeat ($urandom_range(300, 40)) @(posedge clock);
    wr(`OFS_CTRL, 32'h0);
    bus(1'b0, `OFS_T12_CNT, 0, q);
    c12 = q[15:0];
    chk("cnt12 range", 1, 32'(c12 <= 16'h0100));
    bus(1'b0, `OFS_T13_CNT, 0, q);
    c13 = q[15:0];
    wr(`OFS_MASK, 32'h07);
    // every capture channel, rise, fall and both edges, capture and compare mode set together;
    // channel 1 toggles on match so that action runs as well
    for (int ch = 0; ch < 3; ch++)
      for (int e = 0; e < 3; e++)
      begin
        alt = c12 ^ 16'h0001 ^ (16'($urandom) & 16'hfffe);
        wr(`OFS_CH_CFG, cfg(ch, {(ch == 1) ? 3'h3 : 3'h1, 2'(e), 1'b1}));
        wr(`OFS_CC0 + 6'(4 * ch), alt);
        wr(`OFS_STATUS, 32'h7f);
        cur = (e != 1) ? c12 : alt;
        pin(ch);
        bus(1'b0, `OFS_CC0 + 6'(4 * ch), 0, q);
        chk("capture value", 32'(cur), q);
        bus(1'b0, `OFS_STATUS, 0, q);
        chk("status rise", 32'({e != 1, 2'h0, e != 1}), (q >> ch) & 32'h9);
        wr(`OFS_STATUS, 32'h7f);
        pin(ch);
        bus(1'b0, `OFS_STATUS, 0, q);
        chk("status fall", 32'(e != 0), (q >> ch) & 32'h1);
        chk("irq", 32'(e != 0), 32'(irq));
        wr(`OFS_STATUS, 32'h7f);
        repeat (3) @(posedge clock);
        chk("irq clear", 0, 32'(irq));
        // a masked capture must stay off the interrupt line
        wr(`OFS_MASK, 32'h0);
        pin(ch);
        chk("irq masked", 0, 32'(irq));
        // back to a low pin, so the next edge choice starts with a rise
        pin(ch);
        wr(`OFS_MASK, 32'h07);
      end
    // compare modes on channel 0, timer held still
    for (int m = 0; m < 5; m++)
    begin
      wr(`OFS_CC0, c12 ^ 16'h0001);
      wr(`OFS_CH_CFG, cfg(0, {mode_t_[m], 3'h6}));
      wr(`OFS_CC0, (m == 4) ? c12 + 16'h1 : (hit_t_[m] ? c12 : c12 ^ 16'h0001));
      repeat (4) @(posedge clock);
      chk("cmp_out0", 32'(out_t_[m]), 32'(cmp_out[0]));
    end
    wr(`OFS_CC3, c13 + 16'h1);
    repeat (4) @(posedge clock);
    chk("cmp_out3 low count", 1, 32'(cmp_out[3]));
    wr(`OFS_CC3, c13);
    repeat (4) @(posedge clock);
    chk("cmp_out3 equal", 0, 32'(cmp_out[3]));
    pat = 6'($urandom);
    wr(`OFS_PATTERN, pat);
    // sources: none, channel timer only, compare-only timer, that one inverted
    for (int s = 0; s < 4; s++)
    begin
      wr(`OFS_MOD_SEL, sel_t_[s]);
      repeat (4) @(posedge clock);
      chk("pattern", (s == 2) ? 32'h0 : 32'(pat), 32'(pattern_out));
    end
    wr(`OFS_MOD_SEL, 32'h09);
    repeat (4) @(posedge clock);
    chk("pattern combined", 32'h0, 32'(pattern_out));
    // clock enable low must freeze the running channel timer
    wr(`OFS_T12_PER, 32'h0000ffff);
    wr(`OFS_CTRL, 32'h1);
    bus(1'b0, `OFS_T12_CNT, 0, q);
    cur = q[15:0];
    clk_en <= 1'b0;
    repeat (10) @(posedge clock);
    clk_en <= 1'b1;
    bus(1'b0, `OFS_T12_CNT, 0, q);
    chk("frozen count", 32'(cur + 16'h0003), q);
    give_verdict();
  end
endmodule
